// ### icr_far_model.sv
// Purpose: far-end link sender feeding one receive queue
// Assumes: driven on the falling clock edge
// Notes:   ignores cell available only when the caller forces it
// ====
// sender
module icr_far_model (
    input  wire logic  clock_i,
    input  wire logic  cell_available_i,
    output logic [7:0] byte_o,
    output logic       valid_o,
    output logic       sof_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        byte_o  = 8'h00;
        valid_o = 1'b0;
        sof_o   = 1'b0;
    end
    // a refused cell is never started; a forced cell is sent anyway and can overrun the far queue
    task automatic send(input logic [7:0] c [60], input bit force_i);
        if (!force_i && cell_available_i !== 1'b1) begin
            return;
        end
        for (int i = 0; i < 60; i++) begin
            @(negedge clock_i);
            byte_o  <= c[i];
            valid_o <= 1'b1;
            sof_o   <= (i == 0);
        end
        @(negedge clock_i);
        valid_o <= 1'b0;
        sof_o   <= 1'b0;
        byte_o  <= ~byte_o; // idle line must not look like the last byte
    endtask : send
endmodule : icr_far_model

// ### icr_pkg.sv
// Purpose: shared constants and CRC helper for the inband control cell relay
// Assumes: one clock, link byte streams on the same clock as this logic
// Notes:   cell positions are byte indices within the 60-byte cell
//
// Behaviour
// - upstream cell copied onto both links
// - one four-cell receive queue per link
// - control channel round-robins with user traffic
// - send only when active link allows
// - two or more queued cells clear availability
// - insert buffer holds two whole cells
// - optional CRC-32 over last 48 bytes
// - CRC uses the AAL5 generator polynomial
// - inserted cells carry channel identifier 111110
// - every cell is exactly 60 bytes
// - unused bytes carried, values not guaranteed
// - fixed byte layout of the cell
// - optional bytes sent only if both ends include
// - other contents carried across unchanged
// - maskable status: first cell, CRC error, overflow
// - full queue drops whole new cells
// - cells read one byte per access
// - 8-bit processor data path
package icr_pkg;

    localparam int          CELL_BYTES = 60;
    localparam int          INS_CELLS  = 2;
    localparam int          XQ_CELLS   = 4;
    localparam int          CA_LIMIT   = 2;
    localparam logic [5:0]  CHAN_ID    = 6'h3E;
    localparam logic [5:0]  POS_LAST   = 6'h3B;
    localparam logic [5:0]  POS_PRE0   = 6'h02;
    localparam logic [5:0]  POS_PRE1   = 6'h03;
    localparam logic [5:0]  POS_H5     = 6'h08;
    localparam logic [5:0]  POS_UDF    = 6'h09;
    localparam logic [5:0]  POS_PAY    = 6'h0C;
    localparam logic [5:0]  POS_CRC    = 6'h38;
    localparam int          OPT_PRE    = 0;
    localparam int          OPT_H5     = 1;
    localparam int          OPT_UDF    = 2;
    localparam logic [31:0] CRC_POLY   = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT   = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_RESID  = 32'hC704DD7B;
    localparam int          EV_FIRST   = 0;
    localparam int          EV_CRC     = 1;
    localparam int          EV_OVF     = 2;

    typedef logic [5:0] icr_pos_t;

    // msb-first shift, one byte per call
    function automatic logic [31:0] icr_crc_byte(input logic [31:0] c,
                                                 input logic [7:0]  d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
        end
        return r;
    endfunction : icr_crc_byte

endpackage : icr_pkg

// ### icr_relay.sv
// Purpose: control cell insert path and dual extract queues
// Assumes: link byte streams and processor strobes are on clock_i
// Notes:   one insert cell is sent per granted slot, both links alike
module icr_relay
    import icr_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       crc_gen_en_i,
    input  wire logic       active_link_i,
    input  wire logic [2:0] loc_opt_i,
    input  wire logic [2:0] far_opt_i,
    input  wire logic [7:0] ins_byte_i,
    input  wire logic       ins_valid_i,
    output logic            ins_ready_o,
    input  wire logic       slot_i,
    input  wire logic       user_req_i,
    output logic            user_grant_o,
    output logic [7:0]      tx1_byte_o,
    output logic            tx1_valid_o,
    output logic            tx1_sof_o,
    output logic [7:0]      tx2_byte_o,
    output logic            tx2_valid_o,
    output logic            tx2_sof_o,
    output logic            tx1_upstream_cell_available_o,
    output logic            tx2_upstream_cell_available_o,
    input  wire logic       rx1_upstream_cell_available_i,
    input  wire logic       rx2_upstream_cell_available_i,
    input  wire logic [7:0] rx1_byte_i,
    input  wire logic       rx1_valid_i,
    input  wire logic       rx1_sof_i,
    input  wire logic [7:0] rx2_byte_i,
    input  wire logic       rx2_valid_i,
    input  wire logic       rx2_sof_i,
    input  wire logic       rd_link_i,
    input  wire logic       rd_req_i,
    output logic [7:0]      rd_byte_o,
    output logic            rd_valid_o,
    input  wire logic [5:0] stat_mask_i,
    input  wire logic [5:0] stat_clr_i,
    output logic [5:0]      stat_o,
    output logic            irq_o
);
    typedef enum logic [0:0] {TX_IDLE, TX_SEND} icr_tx_t;

    logic [7:0]  ins_q [INS_CELLS][CELL_BYTES];
    logic        iw_cell_q;
    logic        ir_cell_q;
    icr_pos_t    iw_pos_q;
    logic [1:0]  ins_cnt_q;
    icr_tx_t     tx_st_q;
    icr_pos_t    tx_pos_q;
    logic        crc_en_q;
    logic [31:0] tx_crc_q;
    logic        last_ctrl_q;
    logic        grant_q;
    logic [7:0]  tx_byte_q;
    logic        tx_valid_q;
    logic        tx_sof_q;
    logic        rd_sel_q;
    logic [5:0]  stat_q;
    logic        ins_wr;
    logic        ins_done;
    logic        tx_done;
    logic        ca_active;
    logic        ctrl_rdy;
    logic        pick_ctrl;
    logic        pick_user;
    logic [7:0]  raw_byte;
    logic [7:0]  out_byte;
    logic        keep;
    logic [5:0]  ev_all;

    icr_xq_if xq1 ();
    icr_xq_if xq2 ();

    // ==================================================================
    // insert buffer, two whole cells
    assign ins_ready_o = ins_cnt_q != 2'(INS_CELLS);
    assign ins_wr      = ins_valid_i & ins_ready_o;
    assign ins_done    = ins_wr & (iw_pos_q == POS_LAST);
    assign tx_done     = (tx_st_q == TX_SEND) & (tx_pos_q == POS_LAST);

    always_ff @(posedge clock_i) begin
        if (ins_wr) begin
            ins_q[iw_cell_q][iw_pos_q] <= ins_byte_i;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            iw_pos_q  <= '0;
            iw_cell_q <= 1'b0;
        end else if (ins_wr) begin
            iw_pos_q <= ins_done ? 6'h00 : iw_pos_q + 6'h01;
            if (ins_done) begin
                iw_cell_q <= ~iw_cell_q;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ins_cnt_q <= 2'h0;
        end else begin
            ins_cnt_q <= ins_cnt_q + 2'(ins_done) - 2'(tx_done);
        end
    end

    // ==================================================================
    // upstream scheduling
    // flow follows the active link only; the spare copy is best effort
    assign ca_active = active_link_i ? rx2_upstream_cell_available_i
                                     : rx1_upstream_cell_available_i;
    assign ctrl_rdy  = (ins_cnt_q != 2'h0) & ca_active;
    // alternate when both want the slot
    assign pick_ctrl = slot_i & (tx_st_q == TX_IDLE) & ctrl_rdy
                       & (~user_req_i | ~last_ctrl_q);
    assign pick_user = slot_i & (tx_st_q == TX_IDLE) & user_req_i
                       & ~pick_ctrl;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_ctrl_q <= 1'b0;
            grant_q     <= 1'b0;
        end else begin
            grant_q <= pick_user;
            if (pick_ctrl || pick_user) begin
                last_ctrl_q <= pick_ctrl;
            end
        end
    end

    assign user_grant_o = grant_q;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_st_q   <= TX_IDLE;
            tx_pos_q  <= '0;
            ir_cell_q <= 1'b0;
            crc_en_q  <= 1'b0;
        end else begin
            unique case (tx_st_q)
                TX_IDLE: begin
                    if (pick_ctrl) begin
                        tx_st_q  <= TX_SEND;
                        tx_pos_q <= '0;
                        crc_en_q <= crc_gen_en_i;
                    end
                end
                TX_SEND: begin
                    tx_pos_q <= tx_pos_q + 6'h01;
                    if (tx_done) begin
                        tx_st_q   <= TX_IDLE;
                        ir_cell_q <= ~ir_cell_q;
                    end
                end
            endcase
        end
    end

    // ==================================================================
    // outgoing byte shaping
    assign raw_byte = ins_q[ir_cell_q][tx_pos_q];

    always_comb begin
        out_byte = raw_byte;
        if (tx_pos_q == POS_PRE1) begin
            out_byte = {raw_byte[7:6], CHAN_ID};
        end else if (crc_en_q && tx_pos_q >= POS_CRC) begin
            unique case (tx_pos_q[1:0])
                2'h0:    out_byte = ~tx_crc_q[31:24];
                2'h1:    out_byte = ~tx_crc_q[23:16];
                2'h2:    out_byte = ~tx_crc_q[15:8];
                default: out_byte = ~tx_crc_q[7:0];
            endcase
        end
    end

    // positions follow the fixed cell layout
    always_comb begin
        keep = 1'b1;
        if (tx_pos_q == POS_PRE0 || tx_pos_q == POS_PRE1) begin
            keep = loc_opt_i[OPT_PRE] & far_opt_i[OPT_PRE];
        end else if (tx_pos_q == POS_H5) begin
            keep = loc_opt_i[OPT_H5] & far_opt_i[OPT_H5];
        end else if (tx_pos_q == POS_UDF) begin
            keep = loc_opt_i[OPT_UDF] & far_opt_i[OPT_UDF];
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_crc_q <= CRC_INIT;
        end else if (pick_ctrl) begin
            tx_crc_q <= CRC_INIT;
        end else if (tx_st_q == TX_SEND && tx_pos_q >= POS_PAY
                     && tx_pos_q < POS_CRC) begin
            tx_crc_q <= icr_crc_byte(tx_crc_q, raw_byte);
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_byte_q  <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_sof_q   <= 1'b0;
        end else begin
            tx_byte_q  <= out_byte;
            tx_valid_q <= (tx_st_q == TX_SEND) & keep;
            tx_sof_q   <= (tx_st_q == TX_SEND) & (tx_pos_q == 6'h00);
        end
    end

    // same registers feed both links, so the copies cannot differ
    assign tx1_byte_o  = tx_byte_q;
    assign tx1_valid_o = tx_valid_q;
    assign tx1_sof_o   = tx_sof_q;
    assign tx2_byte_o  = tx_byte_q;
    assign tx2_valid_o = tx_valid_q;
    assign tx2_sof_o   = tx_sof_q;

    // ==================================================================
    // extract queues
    assign xq1.rx_byte  = rx1_byte_i;
    assign xq1.rx_valid = rx1_valid_i;
    assign xq1.rx_sof   = rx1_sof_i;
    assign xq1.rd_req   = rd_req_i & ~rd_link_i;
    assign xq2.rx_byte  = rx2_byte_i;
    assign xq2.rx_valid = rx2_valid_i;
    assign xq2.rx_sof   = rx2_sof_i;
    assign xq2.rd_req   = rd_req_i & rd_link_i;

    icr_xfifo #(.CELLS(XQ_CELLS)) u_xq1 (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .q         (xq1.fifo)
    );
    icr_xfifo #(.CELLS(XQ_CELLS)) u_xq2 (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .q         (xq2.fifo)
    );

    // far end is trusted to stop within two slots of this bit dropping
    assign tx1_upstream_cell_available_o = xq1.cell_avail;
    assign tx2_upstream_cell_available_o = xq2.cell_avail;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_sel_q <= 1'b0;
        end else if (rd_req_i) begin
            rd_sel_q <= rd_link_i;
        end
    end

    assign rd_byte_o  = rd_sel_q ? xq2.rd_byte : xq1.rd_byte;
    assign rd_valid_o = xq1.rd_valid | xq2.rd_valid;

    // ==================================================================
    // sticky status; a same-cycle event beats the clear
    assign ev_all = {xq2.ev, xq1.ev};

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stat_q <= 6'h00;
        end else begin
            stat_q <= (stat_q & ~stat_clr_i) | ev_all;
        end
    end

    assign stat_o = stat_q;
    assign irq_o  = |(stat_q & stat_mask_i);

    // ==================================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    link_copy_a: assert property (tx1_valid_o == tx2_valid_o
                                  && tx1_sof_o == tx2_sof_o
                                  && tx1_byte_o == tx2_byte_o)
        else $error("link copies differ");
    ca_thresh_a: assert property (tx1_upstream_cell_available_o
                                  == (xq1.count < 3'h2))
        else $error("cell available wrong for queue fill");
    flow_gate_a: assert property (pick_ctrl |-> ca_active)
        else $error("control cell sent against flow control");
    rr_turn_a: assert property (slot_i && tx_st_q == TX_IDLE && ctrl_rdy
                                && user_req_i && last_ctrl_q
                                |=> user_grant_o)
        else $error("user channel skipped its turn");
    cell_len_a: assert property (pick_ctrl |=> tx_st_q == TX_SEND
                                 ##59 tx_done ##1 tx_st_q == TX_IDLE)
        else $error("sent cell not 60 bytes");
    chan_id_a: assert property (tx_st_q == TX_SEND && tx_pos_q == POS_PRE1
                                |=> tx1_byte_o[5:0] == CHAN_ID)
        else $error("channel identifier missing");
    opt_drop_a: assert property (tx_st_q == TX_SEND && tx_pos_q == POS_H5
                                 && !(loc_opt_i[OPT_H5] && far_opt_i[OPT_H5])
                                 |=> !tx1_valid_o)
        else $error("optional byte sent without both ends");
    ins_full_a: assert property (ins_cnt_q != 2'h3)
        else $error("insert buffer overfilled");
    crc_out_a: assert property (crc_en_q && tx_st_q == TX_SEND
                                && tx_pos_q == POS_CRC
                                |=> tx1_byte_o == ~$past(tx_crc_q[31:24]))
        else $error("generated crc byte wrong");
    stat_set_a: assert property (xq1.ev[EV_OVF] |=> stat_o[EV_OVF])
        else $error("overflow status not set");

    cov_ctrl_c: cover property (pick_ctrl ##1 tx_st_q == TX_SEND [*8]);
    cov_rr_c: cover property (pick_ctrl ##[1:200] pick_user);
    cov_full_c: cover property (xq2.count == 3'h4);
    cov_crc_c: cover property (stat_o[EV_CRC]);
endmodule : icr_relay

// ### icr_xfifo.sv
// Purpose: per-link receive queue for control cells with CRC check
// Assumes: a cell arrives as 60 consecutive valid bytes
// Notes:   a new sof mid-cell abandons the partial cell
module icr_xfifo
    import icr_pkg::*;
#(
    parameter int CELLS = XQ_CELLS
) (
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    icr_xq_if.fifo    q
);
    localparam int CW = $clog2(CELLS);

    logic [7:0]     mem_q [CELLS][CELL_BYTES];
    logic [CW-1:0]  wcell_q;
    logic [CW-1:0]  rcell_q;
    icr_pos_t       wpos_q;
    icr_pos_t       rpos_q;
    logic [2:0]     cnt_q;
    logic           wact_q;
    logic [31:0]    crc_q;
    logic [7:0]     rd_byte_q;
    logic           rd_valid_q;
    logic [2:0]     ev_q;
    logic           full;
    logic           start;
    logic           wbyte;
    logic           commit;
    logic           pop;
    logic [31:0]    crc_d;

    assign full   = cnt_q == 3'(CELLS);
    assign start  = q.rx_valid & q.rx_sof;
    assign wbyte  = q.rx_valid & ~q.rx_sof & wact_q;
    assign commit = wbyte & (wpos_q == POS_LAST);
    assign pop    = q.rd_req & (cnt_q != 3'h0) & (rpos_q == POS_LAST);
    assign crc_d  = (wpos_q >= POS_PAY) ? icr_crc_byte(crc_q, q.rx_byte) : crc_q;

    // ==================================================================
    // storage
    always_ff @(posedge clock_i) begin
        if (start && !full) begin
            mem_q[wcell_q][0] <= q.rx_byte;
        end else if (wbyte) begin
            mem_q[wcell_q][wpos_q] <= q.rx_byte;
        end
    end

    // ==================================================================
    // write side
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wact_q  <= 1'b0;
            wpos_q  <= '0;
            wcell_q <= '0;
            crc_q   <= CRC_INIT;
        end else if (start) begin
            wact_q <= ~full;
            wpos_q <= 6'h01;
            crc_q  <= CRC_INIT;
        end else if (wbyte) begin
            wpos_q <= wpos_q + 6'h01;
            crc_q  <= crc_d;
            if (commit) begin
                wact_q  <= 1'b0;
                wcell_q <= wcell_q + 1'b1;
            end
        end
    end

    // ==================================================================
    // read side, one byte per request
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rpos_q     <= '0;
            rcell_q    <= '0;
            rd_byte_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= q.rd_req & (cnt_q != 3'h0);
            if (q.rd_req && cnt_q != 3'h0) begin
                rd_byte_q <= mem_q[rcell_q][rpos_q];
                rpos_q    <= pop ? 6'h00 : rpos_q + 6'h01;
                if (pop) begin
                    rcell_q <= rcell_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 3'h0;
            ev_q  <= 3'h0;
        end else begin
            cnt_q <= cnt_q + 3'(commit) - 3'(pop);
            ev_q[EV_FIRST] <= commit & (cnt_q == 3'h0);
            ev_q[EV_CRC]   <= commit & (crc_d != CRC_RESID);
            ev_q[EV_OVF]   <= start & full;
        end
    end

    assign q.rd_byte    = rd_byte_q;
    assign q.rd_valid   = rd_valid_q;
    assign q.count      = cnt_q;
    assign q.cell_avail = cnt_q < 3'(CA_LIMIT);
    assign q.ev         = ev_q;

    // ==================================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    depth_bound_a: assert property (cnt_q <= 3'(CELLS))
        else $error("queue count above depth");
    ovf_keep_a: assert property (start && full |=> !wact_q && cnt_q <= $past(cnt_q))
        else $error("full queue accepted or lost cells");
    crc_flag_a: assert property (commit && crc_d != CRC_RESID |=> ev_q[EV_CRC])
        else $error("crc mismatch not flagged");
    cov_ovf_c: cover property (start && full);
endmodule : icr_xfifo

// ### icr_xq_if.sv
// Purpose: carrier between the relay top and one extract queue
// Assumes: all signals on the relay clock
// Notes:   rx_sof marks byte 0 of an arriving cell
interface icr_xq_if;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rx_sof;
    logic       rd_req;
    logic [7:0] rd_byte;
    logic       rd_valid;
    logic [2:0] count;
    logic       cell_avail;
    logic [2:0] ev;

    modport fifo (input  rx_byte, rx_valid, rx_sof, rd_req,
                  output rd_byte, rd_valid, count, cell_avail, ev);
    modport host (output rx_byte, rx_valid, rx_sof, rd_req,
                  input  rd_byte, rd_valid, count, cell_avail, ev);
endinterface : icr_xq_if

// ### inband_control_cell_relay_tb_top.sv
// Purpose: self-checking bench for the inband control cell relay
// Assumes: link 2 active (active_link_i high) for insert sends; inputs change on the falling clock edge
// Notes:   far-end senders feed both receive queues
`define CHK(g, e) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            n_fail++; \
            $display("ERROR %0t got %0h exp %0h", $time, (g), (e)); \
        end \
    end
// ====
// harness
module inband_control_cell_relay_tb_top
    import icr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock_i, sys_rst_i, crc_gen_en_i, active_link_i, ins_valid_i, ins_ready_o;
    logic       slot_i, user_req_i, user_grant_o, tx1_valid_o, tx1_sof_o, tx2_valid_o;
    logic       tx2_sof_o, tx1_upstream_cell_available_o, tx2_upstream_cell_available_o;
    logic       rx1_upstream_cell_available_i, rx2_upstream_cell_available_i, irq_o;
    logic       rx1_valid_i, rx1_sof_i, rx2_valid_i, rx2_sof_i, rd_link_i, rd_req_i, rd_valid_o;
    logic [2:0] loc_opt_i, far_opt_i;
    logic [7:0] ins_byte_i, tx1_byte_o, tx2_byte_o, rx1_byte_i, rx2_byte_i, rd_byte_o;
    logic [5:0] stat_mask_i, stat_clr_i, stat_o;
    logic [7:0] cl [5][60];
    int         n_fail;
    int         comparisons;

    icr_relay u_icr_relay (
        .clock_i, .sys_rst_i, .crc_gen_en_i, .active_link_i, .loc_opt_i, .far_opt_i,
        .ins_byte_i, .ins_valid_i, .ins_ready_o, .slot_i, .user_req_i, .user_grant_o,
        .tx1_byte_o, .tx1_valid_o, .tx1_sof_o, .tx2_byte_o, .tx2_valid_o, .tx2_sof_o,
        .tx1_upstream_cell_available_o, .tx2_upstream_cell_available_o,
        .rx1_upstream_cell_available_i, .rx2_upstream_cell_available_i,
        .rx1_byte_i, .rx1_valid_i, .rx1_sof_i, .rx2_byte_i, .rx2_valid_i, .rx2_sof_i,
        .rd_link_i, .rd_req_i, .rd_byte_o, .rd_valid_o, .stat_mask_i, .stat_clr_i,
        .stat_o, .irq_o
    );
    icr_far_model u_far1 (.clock_i, .cell_available_i(tx1_upstream_cell_available_o),
        .byte_o(rx1_byte_i), .valid_o(rx1_valid_i), .sof_o(rx1_sof_i));
    icr_far_model u_far2 (.clock_i, .cell_available_i(tx2_upstream_cell_available_o),
        .byte_o(rx2_byte_i), .valid_o(rx2_valid_i), .sof_o(rx2_sof_i));

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        #800000;
        n_fail++;
        final_report();
    end
    // ====
    // helpers
    task automatic final_report;
        if (n_fail == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick
    function automatic logic [31:0] crc_of(input logic [7:0] d [60]);
        logic [31:0] r;
        r = 32'hFFFFFFFF;
        for (int i = 12; i < 56; i++) begin
            for (int b = 7; b >= 0; b--) begin
                r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i][b]) ? 32'h04C11DB7 : 32'h00000000);
            end
        end
        return ~r;
    endfunction : crc_of
    // a bad cell keeps the raw pattern where the check word belongs
    task automatic mk(input int s, input bit good);
        for (int i = 0; i < 60; i++) cl[s][i] = 8'(i * 7 + s * 29);
        if (good) {cl[s][56], cl[s][57], cl[s][58], cl[s][59]} = crc_of(cl[s]);
    endtask : mk
    task automatic write_cell(input int s);
        for (int i = 0; i < 60; i++) begin
            `CHK(ins_ready_o, 1'b1)
            ins_byte_i  = cl[s][i];
            ins_valid_i = 1'b1;
            tick(1);
        end
        ins_valid_i = 1'b0;
        tick(1);
    endtask : write_cell
    task automatic send_chk(input int s, input bit crc, input bit ex_g, input bit ex_s);
        logic [7:0]  c [60];
        logic [59:0] v;
        logic [31:0] x;
        logic [2:0]  m;
        logic [7:0]  e;
        int          k;
        bit          g;
        k = -1;
        g = 1'b0;
        x = crc_of(cl[s]);
        m = loc_opt_i & far_opt_i;
        crc_gen_en_i = crc;
        slot_i = 1'b1;
        tick(1);
        slot_i = 1'b0;
        for (int i = 0; i < 70; i++) begin
            if (user_grant_o === 1'b1) g = 1'b1;
            if (tx1_sof_o === 1'b1) k = 0;
            if (k >= 0 && k < 60) begin
                `CHK({tx2_byte_o, tx2_valid_o, tx2_sof_o}, {tx1_byte_o, tx1_valid_o, tx1_sof_o})
                c[k] = tx1_byte_o;
                v[k] = tx1_valid_o;
                k++;
            end
            tick(1);
        end
        `CHK(g, ex_g)
        `CHK(k, ex_s ? 60 : -1)
        for (int j = 0; j < 60 && k == 60; j++) begin
            `CHK(v[j], (j == 2 || j == 3) ? m[0] : j == 8 ? m[1] : j == 9 ? m[2] : 1'b1)
            e = (crc && j >= 56) ? x[8 * (59 - j) +: 8] : cl[s][j];
            if (j == 3 && v[j]) `CHK(c[j][5:0], CHAN_ID)
            else if (v[j]) `CHK(c[j], e)
        end
    endtask : send_chk
    task automatic rd_cell(input int s);
        for (int i = 0; i < 60; i++) begin
            rd_req_i = 1'b1;
            tick(1);
            rd_req_i = 1'b0;
            `CHK({rd_valid_o, rd_byte_o}, {1'b1, cl[s][i]})
            tick(1);
        end
    endtask : rd_cell
    // ====
    // scenarios
    task automatic t_insert;
        mk(0, 0);
        mk(1, 0);
        write_cell(0);
        write_cell(1);
        `CHK(ins_ready_o, 1'b0)
        {active_link_i, rx1_upstream_cell_available_i, rx2_upstream_cell_available_i} = 3'b110;
        send_chk(0, 1, 0, 0);
        {active_link_i, rx1_upstream_cell_available_i, rx2_upstream_cell_available_i} = 3'b101;
        send_chk(0, 1, 0, 1);
        user_req_i = 1'b1;
        send_chk(1, 0, 1, 0);
        far_opt_i = 3'h6;
        send_chk(1, 0, 0, 1);
        user_req_i = 1'b0;
        `CHK(ins_ready_o, 1'b1)
    endtask : t_insert
    // cells 2..4 are forced past a low cell available to overrun the queue
    task automatic t_receive;
        stat_mask_i = 6'h01;
        for (int s = 0; s < 5; s++) begin
            mk(s, 1);
            u_far1.send(cl[s], s >= 2);
            tick(3);
            `CHK({stat_o[0], irq_o}, 2'b11)
            `CHK(tx1_upstream_cell_available_o, s == 0)
            `CHK(stat_o[2], s == 4)
        end
        `CHK(tx2_upstream_cell_available_o, 1'b1)
        for (int s = 0; s < 4; s++) rd_cell(s);
        stat_mask_i = 6'h00;
        rd_req_i = 1'b1;
        tick(1);
        rd_req_i = 1'b0;
        `CHK({rd_valid_o, irq_o, tx1_upstream_cell_available_o}, 3'b001)
    endtask : t_receive
    task automatic t_crc_err;
        stat_mask_i = 6'h10;
        mk(4, 0);
        u_far2.send(cl[4], 0);
        tick(3);
        `CHK({stat_o[4], irq_o}, 2'b11)
        rd_link_i = 1'b1;
        rd_cell(4);
        stat_clr_i = 6'h3F;
        tick(1);
        stat_clr_i = 6'h00;
        `CHK({stat_o, irq_o}, 7'h00)
    endtask : t_crc_err

    initial begin
        {crc_gen_en_i, active_link_i, ins_valid_i, slot_i, user_req_i} = 5'h00;
        {rd_link_i, rd_req_i, ins_byte_i, stat_mask_i, stat_clr_i} = 22'h000000;
        {loc_opt_i, far_opt_i} = 6'h3F;
        {rx1_upstream_cell_available_i, rx2_upstream_cell_available_i} = 2'h3;
        n_fail = 0;
        comparisons = 0;
        sys_rst_i = 1'b1;
        tick(6);
        sys_rst_i = 1'b0;
        tick(1);
        t_insert();
        t_receive();
        t_crc_err();
        final_report();
    end
endmodule : inband_control_cell_relay_tb_top
